// >>> hw/lra_pkg.sv
package lra_pkg;
  // ==========================================================
  // Direct register map
  localparam logic [7:0] ADDR_CFG      = 8'hc9;
  localparam logic [7:0] PAGE_CFG      = 8'h0f;
  localparam logic [7:0] ADDR_DATA     = 8'hd2;
  localparam logic [7:0] ADDR_PTR      = 8'hd3;
  localparam logic [7:0] PAGE_PTR      = 8'h00;
  localparam logic [7:0] CFG_RESET     = 8'h60;
  localparam logic [7:0] CFG_WR_MASK   = 8'he0;
  localparam int         CFG_EN_BIT    = 7;
  localparam int         CFG_MASTER_BIT = 6;
  localparam int         CFG_AUTO_BAUD_SELECT_BIT = 5;
  // ==========================================================
  // Indirect register map
  localparam logic [7:0] IDX_DATA_LAST = 8'h07;
  localparam logic [7:0] IDX_CTRL      = 8'h08;
  localparam logic [7:0] IDX_STAT      = 8'h09;
  localparam logic [7:0] IDX_ERR       = 8'h0a;
  localparam logic [7:0] IDX_SIZE      = 8'h0b;
  localparam logic [7:0] IDX_DIV       = 8'h0c;
  localparam logic [7:0] IDX_MUL       = 8'h0d;
  localparam logic [7:0] IDX_ID        = 8'h0e;
  localparam int         NUM_DATA      = 8;
  // Control bits
  localparam int CTL_START  = 0;
  localparam int CTL_WAKE   = 1;
  localparam int CTL_CLRERR = 2;
  localparam int CTL_CLRINT = 3;
  localparam int CTL_DTACK  = 4;
  localparam int CTL_TXRX   = 5;
  localparam int CTL_SLEEP  = 6;
  localparam int CTL_STOP   = 7;
  // Status bits
  localparam int ST_DONE    = 0;
  localparam int ST_WAKEUP  = 1;
  localparam int ST_ERROR   = 2;
  localparam int ST_INT     = 3;
  localparam int ST_DTREQ   = 4;
  localparam int ST_ABORT   = 5;
  localparam int ST_IDLTO   = 6;
  localparam int ST_ACTIVE  = 7;
  // Role masks: master-only and slave-only bits; then field masks and the length-from-ID code
  localparam logic [7:0] CTL_M_ONLY = 8'h01;
  localparam logic [7:0] CTL_S_ONLY = 8'hd0;
  localparam logic [7:0] ST_S_ONLY  = 8'h30;
  localparam logic [7:0] ERR_S_ONLY = 8'h18;
  localparam logic [7:0] ERR_MASK   = 8'h1f;
  localparam logic [7:0] ID_MASK    = 8'h3f;
  localparam logic [3:0] LEN_FROM_ID = 4'hf;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       en;
    logic       master;
    logic       auto_baud_select;
  } lra_cfg_s;
  typedef struct packed {
    logic       done;
    logic       wakeup;
    logic       dtreq;
    logic       abort;
    logic       idle_timeout;
    logic       active;
    logic [7:0] err;
  } lra_evt_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } lra_frame_e;
endpackage : lra_pkg

// >>> hw/lra_core.sv
`timescale 1ns/1ps
`default_nettype none
module lra_core (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [7:0]       i_sfr_addr,
  input  wire logic [7:0]       i_sfr_page,
  input  wire logic [7:0]       i_sfr_wdata,
  input  wire logic             i_sfr_wr,
  input  wire logic             i_sfr_rd,
  input  wire lra_pkg::lra_evt_s i_evt,
  input  wire logic             i_evt_valid,
  output logic [7:0]            o_sfr_rdata,
  output lra_pkg::lra_cfg_s     o_cfg,
  output logic                  o_irq,
  output logic                  o_start_frame,
  output logic                  o_wakeup_req,
  output logic                  o_abandon_frame,
  output logic                  o_data_ack,
  output logic                  o_stop_req,
  output logic                  o_sleep,
  output logic                  o_tx_dir,
  output logic                  o_len_from_id,
  output logic [3:0]            o_data_length,
  output logic                  o_enh_checksum,
  output logic [7:0]            o_div_low,
  output logic [7:0]            o_mul_prescale,
  output logic [5:0]            o_frame_id
);
  // ==========================================================
  // Storage
  logic [7:0]          frame_data [lra_pkg::NUM_DATA];
  logic [7:0]          indirect_address_pointer;
  lra_pkg::lra_cfg_s   interface_configuration;
  logic [7:0]          frame_control;
  logic [7:0]          frame_status;
  logic [7:0]          error_flags;
  logic [7:0]          length_and_checksum_type;
  logic [7:0]          baud_divider_low;
  logic [7:0]          baud_multiplier_prescale;
  logic [7:0]          frame_identifier;
  lra_pkg::lra_frame_e frame_state;
  lra_pkg::lra_frame_e next_frame_state;
  // ==========================================================
  // Decode
  wire        page_ptr     = (i_sfr_page == lra_pkg::PAGE_PTR);
  wire        sel_ptr      = page_ptr && (i_sfr_addr == lra_pkg::ADDR_PTR);
  wire        sel_dat      = page_ptr && (i_sfr_addr == lra_pkg::ADDR_DATA);
  wire        sel_cfg      = (i_sfr_page == lra_pkg::PAGE_CFG)
                             && (i_sfr_addr == lra_pkg::ADDR_CFG);
  wire        ptr_valid    = (indirect_address_pointer <= lra_pkg::IDX_ID);
  wire        dat_wr       = i_sfr_wr && sel_dat && ptr_valid;
  wire        is_master    = interface_configuration.master;
  wire [7:0]  role_ctl     = is_master ? ~lra_pkg::CTL_S_ONLY : ~lra_pkg::CTL_M_ONLY;
  wire [7:0]  role_st      = is_master ? ~lra_pkg::ST_S_ONLY : 8'hff;
  wire [7:0]  role_err     = is_master ? ~lra_pkg::ERR_S_ONLY : 8'hff;
  wire        wr_ctrl      = dat_wr && (indirect_address_pointer == lra_pkg::IDX_CTRL);
  wire [7:0]  ctl_wr_val   = i_sfr_wdata & role_ctl;
  wire        clr_error    = wr_ctrl && ctl_wr_val[lra_pkg::CTL_CLRERR];
  wire        clr_int      = wr_ctrl && ctl_wr_val[lra_pkg::CTL_CLRINT];
  wire        err_flag     = frame_status[lra_pkg::ST_ERROR];
  wire        start_ok     = wr_ctrl && ctl_wr_val[lra_pkg::CTL_START]
                             && !err_flag && interface_configuration.en;
  wire        wake_ok      = wr_ctrl && ctl_wr_val[lra_pkg::CTL_WAKE]
                             && !err_flag && interface_configuration.en;
  wire [7:0]  new_err      = i_evt_valid ? (i_evt.err & lra_pkg::ERR_MASK) : 8'h00;
  wire        err_event    = |new_err;
  wire        done_event   = i_evt_valid && (i_evt.done || i_evt.wakeup || i_evt.dtreq
                                             || i_evt.idle_timeout);
  wire        int_event    = err_event || done_event;
  wire [7:0]  ctrl_rd      = frame_control & role_ctl & 8'h73; // Write-only bits read 0
  wire [7:0]  core_rd      =
    (indirect_address_pointer <= lra_pkg::IDX_DATA_LAST)
      ? frame_data[indirect_address_pointer[2:0]] :
    (indirect_address_pointer == lra_pkg::IDX_CTRL) ? ctrl_rd :
    (indirect_address_pointer == lra_pkg::IDX_STAT) ? (frame_status & role_st) :
    (indirect_address_pointer == lra_pkg::IDX_ERR)  ? (error_flags & role_err) :
    (indirect_address_pointer == lra_pkg::IDX_SIZE) ? length_and_checksum_type :
    (indirect_address_pointer == lra_pkg::IDX_DIV)  ? baud_divider_low :
    (indirect_address_pointer == lra_pkg::IDX_MUL)  ? baud_multiplier_prescale :
    (indirect_address_pointer == lra_pkg::IDX_ID)   ? (frame_identifier & lra_pkg::ID_MASK) :
    8'h00;
  wire [7:0]  cfg_rd       = {interface_configuration, 5'h00};
  wire [7:0]  next_rdata   = sel_ptr ? indirect_address_pointer :
                             sel_dat ? core_rd :
                             sel_cfg ? cfg_rd : 8'h00;
  // ==========================================================
  // Frame tracking: an error abandons the frame in progress
  always_comb begin
    next_frame_state = frame_state;
    case (frame_state)
      lra_pkg::ST_IDLE: if (start_ok || wake_ok) next_frame_state = lra_pkg::ST_BUSY;
      lra_pkg::ST_BUSY: if (err_event || done_event) next_frame_state = lra_pkg::ST_IDLE;
      default:          next_frame_state = lra_pkg::ST_IDLE;
    endcase
  end
  // ==========================================================
  // Direct registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      indirect_address_pointer <= 8'h00;
      interface_configuration  <= lra_pkg::lra_cfg_s'(lra_pkg::CFG_RESET[7:5]);
      o_sfr_rdata              <= 8'h00;
      frame_state              <= lra_pkg::ST_IDLE;
    end else begin
      frame_state <= next_frame_state;
      if (i_sfr_wr && sel_ptr) begin
        indirect_address_pointer <= i_sfr_wdata;
      end
      if (i_sfr_wr && sel_cfg) begin
        interface_configuration <= lra_pkg::lra_cfg_s'(i_sfr_wdata[7:5]);
      end
      if (i_sfr_rd) begin
        o_sfr_rdata <= next_rdata;
      end
    end
  end
  // ==========================================================
  // Data buffer
  genvar g;
  generate
    for (g = 0; g < lra_pkg::NUM_DATA; g++) begin : g_data
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          frame_data[g] <= 8'h00;
        end else if (dat_wr && (indirect_address_pointer == 8'(g))) begin
          frame_data[g] <= i_sfr_wdata;
        end
      end
    end
  endgenerate
  // ==========================================================
  // Plain indirect registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      length_and_checksum_type <= 8'h00;
      baud_divider_low         <= 8'h00;
      baud_multiplier_prescale <= 8'h00;
      frame_identifier         <= 8'h00;
    end else if (dat_wr) begin
      if (indirect_address_pointer == lra_pkg::IDX_SIZE) length_and_checksum_type <= i_sfr_wdata;
      if (indirect_address_pointer == lra_pkg::IDX_DIV)  baud_divider_low <= i_sfr_wdata;
      if (indirect_address_pointer == lra_pkg::IDX_MUL)  baud_multiplier_prescale <= i_sfr_wdata;
      if (indirect_address_pointer == lra_pkg::IDX_ID)   frame_identifier <= i_sfr_wdata & lra_pkg::ID_MASK;
    end
  end
  // ==========================================================
  // Control register; request bits self-clear after one cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      frame_control <= 8'h00;
    end else if (wr_ctrl) begin
      frame_control <= ctl_wr_val & 8'h73;
      frame_control[lra_pkg::CTL_START] <= start_ok;
      frame_control[lra_pkg::CTL_WAKE]  <= wake_ok;
    end else begin
      frame_control[lra_pkg::CTL_START] <= 1'b0;
      frame_control[lra_pkg::CTL_WAKE]  <= 1'b0;
      frame_control[lra_pkg::CTL_DTACK] <= 1'b0;
    end
  end
  // ==========================================================
  // Status and error flags; a new event wins over a clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      frame_status <= 8'h00;
      error_flags  <= 8'h00;
    end else begin
      error_flags <= (clr_error ? 8'h00 : error_flags) | new_err;
      frame_status[lra_pkg::ST_ERROR] <= (err_flag && !clr_error) || err_event;
      frame_status[lra_pkg::ST_INT]   <= (frame_status[lra_pkg::ST_INT] && !clr_int)
                                         || int_event;
      if (i_evt_valid) begin
        frame_status[lra_pkg::ST_DONE]   <= i_evt.done;
        frame_status[lra_pkg::ST_WAKEUP] <= i_evt.wakeup;
        frame_status[lra_pkg::ST_DTREQ]  <= i_evt.dtreq;
        frame_status[lra_pkg::ST_ABORT]  <= i_evt.abort;
        frame_status[lra_pkg::ST_IDLTO]  <= i_evt.idle_timeout;
        frame_status[lra_pkg::ST_ACTIVE] <= i_evt.active;
      end
    end
  end
  // ==========================================================
  // Outputs to the frame engine
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cfg           <= lra_pkg::lra_cfg_s'(lra_pkg::CFG_RESET[7:5]);
      o_irq           <= 1'b0;
      o_start_frame   <= 1'b0;
      o_wakeup_req    <= 1'b0;
      o_abandon_frame <= 1'b0;
      o_data_ack      <= 1'b0;
      o_stop_req      <= 1'b0;
      o_sleep         <= 1'b0;
      o_tx_dir        <= 1'b0;
      o_len_from_id   <= 1'b0;
      o_data_length   <= 4'h0;
      o_enh_checksum  <= 1'b0;
      o_div_low       <= 8'h00;
      o_mul_prescale  <= 8'h00;
      o_frame_id      <= 6'h00;
    end else begin
      o_cfg           <= interface_configuration;
      o_irq           <= frame_status[lra_pkg::ST_INT];
      o_start_frame   <= start_ok && is_master;
      o_wakeup_req    <= wake_ok;
      o_abandon_frame <= err_event && (frame_state == lra_pkg::ST_BUSY);
      o_data_ack      <= wr_ctrl && ctl_wr_val[lra_pkg::CTL_DTACK];
      o_stop_req      <= wr_ctrl && ctl_wr_val[lra_pkg::CTL_STOP];
      o_sleep         <= frame_control[lra_pkg::CTL_SLEEP];
      o_tx_dir        <= frame_control[lra_pkg::CTL_TXRX];
      o_len_from_id   <= (length_and_checksum_type[3:0] == lra_pkg::LEN_FROM_ID);
      o_data_length   <= length_and_checksum_type[3:0];
      o_enh_checksum  <= length_and_checksum_type[7];
      o_div_low       <= baud_divider_low;
      o_mul_prescale  <= baud_multiplier_prescale;
      o_frame_id      <= frame_identifier[5:0];
    end
  end
endmodule : lra_core
`default_nettype wire

// >>> sim/lra_frame_partner.sv
`timescale 1ns/1ps
`default_nettype none
module lra_frame_partner #(
  parameter int DELAY = 4
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_wake,
  input  wire logic [7:0]  i_err_code,
  output lra_pkg::lra_evt_s o_evt,
  output logic             o_evt_valid
);
  // ==========================================================
  // Frame engine stand-in: report done or the commanded errors
  logic [7:0] cnt;
  wire lra_pkg::lra_evt_s rep = {i_err_code == 8'h00, 5'h00, i_err_code};
  // Outside a report the lines carry a wrong pattern
  assign o_evt = o_evt_valid ? rep : ~rep;
  always_ff @(posedge i_sys_clk) begin
    o_evt_valid <= 1'b0;
    if (i_rst)
      cnt <= 8'h00;
    else if (i_start || i_wake)
      cnt <= 8'(DELAY);
    else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      o_evt_valid <= cnt == 8'h01;
    end
  end
endmodule : lra_frame_partner
`default_nettype wire

// >>> sim/lra_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lra_core_properties (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic [7:0]        i_sfr_addr,
  input wire logic [7:0]        i_sfr_page,
  input wire logic [7:0]        i_sfr_wdata,
  input wire logic              i_sfr_wr,
  input wire logic              i_sfr_rd,
  input wire lra_pkg::lra_evt_s i_evt,
  input wire logic              i_evt_valid,
  input wire logic [7:0]        o_sfr_rdata,
  input wire lra_pkg::lra_cfg_s o_cfg,
  input wire logic              o_irq,
  input wire logic              o_start_frame,
  input wire logic              o_wakeup_req,
  input wire logic              o_abandon_frame,
  input wire logic              o_data_ack,
  input wire logic              o_len_from_id
);
  // ==========================================================
  // Decode and shadow state
  logic [7:0] ptr;
  logic [2:0] cfg_last;
  logic       len_f;
  logic       err_pend;
  wire hit_ptr = i_sfr_page == lra_pkg::PAGE_PTR && i_sfr_addr == lra_pkg::ADDR_PTR;
  wire hit_dat = i_sfr_page == lra_pkg::PAGE_PTR && i_sfr_addr == lra_pkg::ADDR_DATA;
  wire hit_cfg = i_sfr_page == lra_pkg::PAGE_CFG && i_sfr_addr == lra_pkg::ADDR_CFG;
  wire dat_wr  = i_sfr_wr && hit_dat;
  wire start_w = dat_wr && ptr == lra_pkg::IDX_CTRL && i_sfr_wdata[0];
  wire err_w   = i_evt_valid && (i_evt.err & lra_pkg::ERR_MASK) != 8'h00;
  wire clr_w   = dat_wr && ptr == lra_pkg::IDX_CTRL && i_sfr_wdata[2];
  always_ff @(posedge i_sys_clk) begin
    ptr <= i_rst ? 8'h00 : (i_sfr_wr && hit_ptr) ? i_sfr_wdata : ptr;
    cfg_last <= (i_sfr_wr && hit_cfg) ? i_sfr_wdata[7:5] : cfg_last;
    len_f <= (dat_wr && ptr == lra_pkg::IDX_SIZE) ? i_sfr_wdata[3:0] == 4'hf : len_f;
    err_pend <= i_rst ? 1'b0 : (err_pend && !clr_w) || err_w;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence err_evt_s; err_w; endsequence
  sequence cfg_wr_s; i_sfr_wr && hit_cfg; endsequence
  sequence size_wr_s; dat_wr && ptr == lra_pkg::IDX_SIZE; endsequence
  // ==========================================================
  // Properties
  start_cause_a: assert property (
    o_start_frame |-> o_cfg.en && o_cfg.master && ($past(start_w) || $past(start_w, 2)))
    else $error("start without request");
  err_block_a: assert property (
    o_start_frame || o_wakeup_req |-> !$past(err_pend))
    else $error("request accepted while error pending");
  err_irq_a: assert property (err_evt_s |-> ##[1:3] o_irq)
    else $error("no irq after error");
  err_abandon_a: assert property (
    o_abandon_frame |-> $past(err_w) || $past(err_w, 2))
    else $error("abandon without error");
  reset_cfg_a: assert property (
    $fell(i_rst) |-> o_cfg == 3'b011 && !o_irq)
    else $error("bad reset state");
  cfg_track_a: assert property (cfg_wr_s |=> ##1 o_cfg == cfg_last)
    else $error("config not applied");
  unmapped_read_a: assert property (
    i_sfr_rd && !hit_ptr && !hit_dat && !hit_cfg |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read");
  cfg_low_a: assert property (
    i_sfr_rd && hit_cfg |=> o_sfr_rdata[4:0] == 5'h00)
    else $error("config low bits");
  ptr_read_a: assert property (i_sfr_rd && hit_ptr |=> o_sfr_rdata == $past(ptr))
    else $error("pointer read");
  high_ptr_a: assert property (
    i_sfr_rd && hit_dat && ptr > 8'h0e |=> o_sfr_rdata == 8'h00)
    else $error("high pointer read");
  len_decode_a: assert property (size_wr_s |=> ##1 o_len_from_id == len_f)
    else $error("length decode");
  slave_gate_a: assert property (o_data_ack |-> !o_cfg.master)
    else $error("ack in master mode");
endmodule : lra_core_properties
bind lra_core lra_core_properties i_lra_core_properties (
  .i_sys_clk, .i_rst, .i_sfr_addr, .i_sfr_page, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .i_evt,
  .i_evt_valid, .o_sfr_rdata, .o_cfg, .o_irq, .o_start_frame, .o_wakeup_req,
  .o_abandon_frame, .o_data_ack, .o_len_from_id);
`default_nettype wire

// >>> sim/lin_register_access_and_errors_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lin_register_access_and_errors_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, evv, irq, stf, wak, ack, lfi;
  logic abn, ehc, txd, slp, stp;
  logic [7:0] pg = 0, ad = 0, wd = 0, ec = 0, rdata, dv, mul;
  logic [5:0] fid;
  logic [3:0] dl;
  lra_pkg::lra_evt_s evt;
  lra_pkg::lra_cfg_s cfg;
  int fail_count = 0, samples_checked = 0, reqs = 0, acks = 0, abns = 0, stops = 0;
  always #25 clk = ~clk;
  // Pulses are counted mid-cycle, where they are settled
  always @(negedge clk) begin
    if (stf || wak) reqs++;
    if (ack) acks++;
    if (abn) abns++;
    if (stp) stops++;
  end
  lra_core i_lra_core (.i_sys_clk(clk), .i_rst(rst), .i_sfr_addr(ad), .i_sfr_page(pg),
    .i_sfr_wdata(wd), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_evt(evt), .i_evt_valid(evv),
    .o_sfr_rdata(rdata), .o_cfg(cfg), .o_irq(irq), .o_start_frame(stf), .o_wakeup_req(wak),
    .o_abandon_frame(abn), .o_data_ack(ack), .o_stop_req(stp), .o_sleep(slp), .o_tx_dir(txd),
    .o_len_from_id(lfi), .o_data_length(dl), .o_enh_checksum(ehc), .o_div_low(dv),
    .o_mul_prescale(mul), .o_frame_id(fid));
  lra_frame_partner i_lra_frame_partner (.i_sys_clk(clk), .i_rst(rst), .i_start(stf),
    .i_wake(wak), .i_err_code(ec), .o_evt(evt), .o_evt_valid(evv));
  // ==========================================================
  // Access tasks
  task automatic final_report;
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wrt(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {pg, ad, wd, wr} = {p, a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask : wrt
  task automatic rdc(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {pg, ad, rd} = {p, a, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rdc
  task automatic iw(input logic [7:0] a, input logic [7:0] d);
    wrt(8'h00, 8'hd3, a);
    wrt(8'h00, 8'hd2, d);
  endtask : iw
  task automatic ir(input logic [7:0] a, input logic [7:0] e);
    wrt(8'h00, 8'hd3, a);
    rdc(8'h00, 8'hd2, e);
  endtask : ir
  task automatic wait_irq;
    for (int n = 0; n < 50 && irq !== 1'b1; n++) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    if (irq !== 1'b1) final_report();
  endtask : wait_irq
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdc(8'h0f, 8'hc9, 8'h60);
    rdc(8'h00, 8'hd3, 8'h00);
    chk({5'h00, cfg}, 8'h03);
  endtask : t_reset
  task automatic t_cfg;
    wrt(8'h0f, 8'hc9, 8'hff);
    rdc(8'h0f, 8'hc9, 8'he0);
    rdc(8'h00, 8'hc9, 8'h00);
    wrt(8'h0f, 8'hc9, 8'hc0);
    rdc(8'h0f, 8'hc9, 8'hc0);
    chk({5'h00, cfg}, 8'h06);
  endtask : t_cfg
  task automatic t_indirect;
    for (int i = 0; i < 8; i++) iw(8'(i), 8'h41 + 8'(i));
    for (int i = 0; i < 8; i++) ir(8'(i), 8'h41 + 8'(i));
    iw(8'h08, 8'h20);
    iw(8'h0c, 8'h5a);
    iw(8'h0d, 8'ha5);
    iw(8'h0e, 8'h11);
    iw(8'h0b, 8'h0f);
    iw(8'h0f, 8'h77);
    @(negedge clk);
    chk(dv, 8'h5a);
    chk(mul, 8'ha5);
    chk({7'h00, txd}, 8'h01);
    chk({2'h0, fid}, 8'h11);
    chk({7'h00, lfi}, 8'h01);
    ir(8'h0f, 8'h00);
    ir(8'h0e, 8'h11);
    rdc(8'h00, 8'hd3, 8'h0e);
    ir(8'h08, 8'h20);
    iw(8'h0b, 8'h88);
    @(negedge clk);
    chk({3'h0, lfi, dl}, 8'h08);
    chk({7'h00, ehc}, 8'h01);
  endtask : t_indirect
  task automatic t_error;
    int n0;
    ec = 8'h01;
    iw(8'h08, 8'h01);
    wait_irq();
    chk(8'(abns), 8'h01);
    ir(8'h0a, 8'h01);
    ir(8'h09, 8'h0c);
    n0 = reqs;
    iw(8'h08, 8'h01);
    iw(8'h08, 8'h02);
    repeat (4) @(negedge clk);
    chk(8'(reqs - n0), 8'h00);
    ec = 8'h00;
    iw(8'h08, 8'h04);
    ir(8'h0a, 8'h00);
    ir(8'h09, 8'h08);
    iw(8'h08, 8'h08);
    @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    ir(8'h08, 8'h00);
    iw(8'h08, 8'h01);
    wait_irq();
    chk(8'(reqs - n0), 8'h01);
    ir(8'h09, 8'h09);
    chk(8'(abns), 8'h01);
  endtask : t_error
  task automatic t_role;
    int a0, n0;
    a0 = acks;
    iw(8'h08, 8'h10);
    wrt(8'h0f, 8'hc9, 8'h80);
    repeat (2) @(negedge clk);
    chk({5'h00, cfg}, 8'h04);
    n0 = reqs;
    iw(8'h08, 8'h10);
    iw(8'h08, 8'h01);
    repeat (4) @(negedge clk);
    chk(8'(acks - a0), 8'h01);
    chk(8'(reqs - n0), 8'h00);
    iw(8'h08, 8'hc2);
    repeat (4) @(negedge clk);
    chk(8'(reqs - n0), 8'h01);
    chk(8'(stops), 8'h01);
    chk({7'h00, slp}, 8'h01);
    ir(8'h08, 8'h40);
  endtask : t_role
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_reset();
    t_cfg();
    t_indirect();
    t_error();
    t_role();
    final_report();
  end
endmodule : lin_register_access_and_errors_bench
`default_nettype wire
